// ===== design/tuner_config_register_bank.sv
/*
  Configuration and status register bank of a broadcast tuner, reached by
  a host over a two-wire serial bus; also the shutdown and reference-select
  pin controls. Assumes SCL no faster than ref_clk/8 and status inputs that are
  already synchronous to ref_clk.
*/
`timescale 1ns/1ps

module tuner_config_register_bank
  import tuner_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic shutdownPinN,
  input wire logic refSelectPin,
  input wire logic [1:0] pumpCurrentActual,
  input wire logic autoselectSuccess,
  input wire logic autoselectIdle,
  input wire logic [1:0] selOscIndex,
  input wire logic [2:0] selSubband,
  input wire logic [2:0] tuneSampleCode,
  output logic [7:0] diagnosticTrimConfig,
  output logic [7:0] synthLoopConfig,
  output logic [7:0] oscBandSelect,
  output logic [7:0] signalPathControl,
  output logic [7:0] refclkDividerPower,
  output logic [7:0] clockInScaleValue,
  output logic [12:0] loopDivide,
  output logic extRefEnable,
  output logic crystalEnable,
  output logic busActive,
  output logic chipActive,
  output logic synthActive,
  output logic quadOutputEnable
);

  // ------------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------------
  logic shutdownN;
  logic refSelect;
  logic sdaLevel;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic powered;

  bus_pin_sampler pins (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .sclPin(sclPin),
    .sdaPin(sdaPin),
    .shutdownPinN(shutdownPinN),
    .refSelectPin(refSelectPin),
    .shutdownN(shutdownN),
    .refSelect(refSelect),
    .sdaLevel(sdaLevel),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  // Shutdown acts as a second reset for all logic below
  assign powered = nrst && shutdownN;

  // ------------------------------------------------------------------
  // Status byte assembly
  // ------------------------------------------------------------------
  logic powerCycledFlag;

  // Index 0 is the first status byte, index 1 the second
  function automatic logic [7:0] statusByte(input logic idx);
    logic [7:0] b;
    b = 8'h00;
    if (!idx) begin
      b[ST1_PUMP_LSB +: 2] = pumpCurrentActual;
      b[ST1_POWER_CYCLED_BIT] = powerCycledFlag;
      b[ST1_AUTOSEL_SUCCESS_BIT] = autoselectSuccess;
      b[ST1_AUTOSEL_IDLE_BIT] = autoselectIdle;
    end else begin
      b[ST2_OSC_INDEX_LSB +: 2] = selOscIndex;
      b[ST2_SUBBAND_LSB +: 3] = selSubband;
      b[2:0] = tuneSampleCode;
    end
    return b;
  endfunction

  // True for addresses that name a configuration register
  function automatic logic isCfgAddr(input logic [7:0] a);
    return a < 8'(NUM_CFG);
  endfunction

  // ------------------------------------------------------------------
  // Bus engine state
  // ------------------------------------------------------------------
  bus_state_type state;
  bus_state_type next_state;
  logic [3:0] bitCnt;
  logic [3:0] next_bitCnt;
  logic [7:0] shifter;
  logic [7:0] next_shifter;
  logic [7:0] regPtr;
  logic [7:0] next_regPtr;
  logic readMode;
  logic next_readMode;
  logic statusIdx;
  logic next_statusIdx;
  logic hostAck;
  logic next_hostAck;
  logic next_powerCycledFlag;
  logic [7:0] cfg [NUM_CFG];
  logic [7:0] next_cfg [NUM_CFG];
  logic wrEn;
  logic [2:0] wrIdx;

  // Byte-level protocol: sample on SCL rise, change SDA after SCL fall
  always_comb begin
    next_state = state;
    next_bitCnt = bitCnt;
    next_shifter = shifter;
    next_regPtr = regPtr;
    next_readMode = readMode;
    next_statusIdx = statusIdx;
    next_hostAck = hostAck;
    next_powerCycledFlag = powerCycledFlag;
    wrEn = 1'b0;
    wrIdx = regPtr[2:0];
    if (startSeen) begin
      next_state = ADDR_BYTE;
      next_bitCnt = 4'h0;
      next_readMode = 1'b0;
    end else if (stopSeen) begin
      next_state = IDLE;
      // Closing a read clears the flag
      if (readMode) begin
        next_powerCycledFlag = 1'b0;
      end
      next_readMode = 1'b0;
    end else begin
      case (state)
        IDLE: begin
          next_bitCnt = 4'h0;
        end
        ADDR_BYTE, REG_BYTE, WDATA_BYTE: begin
          if (sclRise && bitCnt != BITS_PER_BYTE) begin
            next_shifter = {shifter[6:0], sdaLevel};
            next_bitCnt = bitCnt + 4'h1;
          end else if (sclFall && bitCnt == BITS_PER_BYTE) begin
            next_bitCnt = 4'h0;
            case (state)
              ADDR_BYTE: begin
                // Foreign addresses are left alone until the next START
                if (shifter[7:1] == DEVICE_ADDR) begin
                  next_state = ADDR_ACK;
                  next_readMode = shifter[0];
                end else begin
                  next_state = IDLE;
                end
              end
              REG_BYTE: begin
                next_regPtr = shifter;
                next_state = REG_ACK;
              end
              default: begin
                // Writes past the last register are acked but dropped
                wrEn = isCfgAddr(regPtr);
                next_regPtr = regPtr + 8'h01;
                next_state = WDATA_ACK;
              end
            endcase
          end
        end
        ADDR_ACK, REG_ACK, WDATA_ACK: begin
          if (sclFall) begin
            if (state == ADDR_ACK && readMode) begin
              // Status bytes carry no address: each read starts at byte one
              next_statusIdx = 1'b1;
              next_shifter = statusByte(1'b0);
              next_state = RDATA_BYTE;
            end else begin
              next_state = (state == ADDR_ACK) ? REG_BYTE : WDATA_BYTE;
            end
          end
        end
        RDATA_BYTE: begin
          if (sclRise) begin
            next_bitCnt = bitCnt + 4'h1;
          end else if (sclFall) begin
            if (bitCnt == BITS_PER_BYTE) begin
              next_bitCnt = 4'h0;
              next_state = RDATA_ACK;
            end else begin
              next_shifter = {shifter[6:0], 1'b0};
            end
          end
        end
        RDATA_ACK: begin
          if (sclRise) begin
            next_hostAck = !sdaLevel;
          end else if (sclFall) begin
            if (hostAck) begin
              next_shifter = statusByte(statusIdx);
              next_statusIdx = !statusIdx;
              next_state = RDATA_BYTE;
            end else begin
              next_state = IDLE;
            end
          end
        end
        default: begin
          next_state = IDLE;
        end
      endcase
    end
  end

  // Write port of the configuration array
  generate
    for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
      always_comb begin
        next_cfg[i] = cfg[i];
        if (wrEn && wrIdx == 3'(i)) begin
          next_cfg[i] = shifter;
        end
      end
    end
  endgenerate

  // Shutdown resets the bus engine and loads the registers with CFG_RESET; soft power-down does not
  always_ff @(posedge ref_clk) begin
    if (!powered) begin
      state <= IDLE;
      bitCnt <= 4'h0;
      shifter <= 8'h00;
      regPtr <= 8'h00;
      readMode <= 1'b0;
      statusIdx <= 1'b0;
      hostAck <= 1'b0;
      powerCycledFlag <= 1'b1;
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg[i] <= CFG_RESET[i];
      end
    end else begin
      state <= next_state;
      bitCnt <= next_bitCnt;
      shifter <= next_shifter;
      regPtr <= next_regPtr;
      readMode <= next_readMode;
      statusIdx <= next_statusIdx;
      hostAck <= next_hostAck;
      powerCycledFlag <= next_powerCycledFlag;
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg[i] <= next_cfg[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // Pin drive and outputs
  // ------------------------------------------------------------------
  // Open drain: only ever pulls low, and never while shut down
  assign sdaOut = 1'b0;
  assign sdaOe = powered && (state == ADDR_ACK || state == REG_ACK ||
    state == WDATA_ACK || (state == RDATA_BYTE && !shifter[7]));

  assign diagnosticTrimConfig = cfg[ADDR_DIAG_TRIM[2:0]];
  assign synthLoopConfig = cfg[ADDR_SYNTH_LOOP[2:0]];
  assign oscBandSelect = cfg[ADDR_OSC_BAND[2:0]];
  assign signalPathControl = cfg[ADDR_SIGNAL_PATH[2:0]];
  assign refclkDividerPower = cfg[ADDR_REFCLK_DIV_PWR[2:0]];
  assign clockInScaleValue = cfg[ADDR_CLOCK_IN_SCALE[2:0]];
  assign loopDivide = {cfg[ADDR_LOOP_DIV_HIGH[2:0]],
    cfg[ADDR_LOOP_DIV_LOW[2:0]][7:LOOP_LOW_LSB]};

  // Reference source follows the pin; both off while shut down
  assign extRefEnable = powered && refSelect;
  assign crystalEnable = powered && !refSelect;

  // Pin shutdown overrides every software power setting
  assign busActive = powered;
  assign chipActive = powered && !refclkDividerPower[SOFT_POWERDOWN_BIT];
  assign synthActive = chipActive && !refclkDividerPower[SOFT_STANDBY_BIT];
  assign quadOutputEnable = synthActive &&
    !refclkDividerPower[QUAD_OUTPUT_DISABLE_BIT];

endmodule

// ===== design/tuner_cfg_pkg.sv
/*
  Shared constants and types of the tuner configuration register bank:
  register indexes, field positions, reset values, bus address and timing.
  Assumes a single 20 MHz clock domain in the device that imports it.
*/
package tuner_cfg_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int NUM_CFG = 8;
  localparam logic [7:0] ADDR_DIAG_TRIM = 8'h00;
  localparam logic [7:0] ADDR_SYNTH_LOOP = 8'h01;
  localparam logic [7:0] ADDR_OSC_BAND = 8'h02;
  localparam logic [7:0] ADDR_SIGNAL_PATH = 8'h03;
  localparam logic [7:0] ADDR_REFCLK_DIV_PWR = 8'h04;
  localparam logic [7:0] ADDR_CLOCK_IN_SCALE = 8'h05;
  localparam logic [7:0] ADDR_LOOP_DIV_HIGH = 8'h06;
  localparam logic [7:0] ADDR_LOOP_DIV_LOW = 8'h07;

  // Reset values are the recommended defaults, indexed by address
  localparam logic [7:0] CFG_RESET [NUM_CFG] = '{
    8'h10, 8'hf1, 8'hd8, 8'h56, 8'h08, 8'h38, 8'h53, 8'hf8
  };

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int SOFT_POWERDOWN_BIT = 2;
  localparam int SOFT_STANDBY_BIT = 1;
  localparam int QUAD_OUTPUT_DISABLE_BIT = 0;
  localparam int LOOP_LOW_LSB = 3;
  localparam int ST1_PUMP_LSB = 3;
  localparam int ST1_POWER_CYCLED_BIT = 2;
  localparam int ST1_AUTOSEL_SUCCESS_BIT = 1;
  localparam int ST1_AUTOSEL_IDLE_BIT = 0;
  localparam int ST2_OSC_INDEX_LSB = 6;
  localparam int ST2_SUBBAND_LSB = 3;

  // ------------------------------------------------------------------
  // Serial bus and timing
  // ------------------------------------------------------------------
  localparam logic [6:0] DEVICE_ADDR = 7'h61; // Arbitrary value
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int POWERUP_WAIT_US = 100;
  // Least time; exact for a whole-MHz clock, so no rounding term is added
  localparam int POWERUP_WAIT_CYCLES =
    (POWERUP_WAIT_US * (CLK_FREQ_HZ / 1_000_000) + 0);

  typedef enum {
    IDLE, ADDR_BYTE, ADDR_ACK, REG_BYTE, REG_ACK,
    WDATA_BYTE, WDATA_ACK, RDATA_BYTE, RDATA_ACK
  } bus_state_type;

endpackage

// ===== design/bus_pin_sampler.sv
/*
  Two-flop synchronisers for the serial bus pins, the shutdown pin and the
  reference-select pin, plus edge and START/STOP detection on the bus.
  Assumes pins are asynchronous to ref_clk and SCL is far slower than it.
*/
`timescale 1ns/1ps

module bus_pin_sampler
  import tuner_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic sclPin,
  input wire logic sdaPin,
  input wire logic shutdownPinN,
  input wire logic refSelectPin,
  output logic shutdownN,
  output logic refSelect,
  output logic sdaLevel,
  output logic sclRise,
  output logic sclFall,
  output logic startSeen,
  output logic stopSeen
);

  // ------------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------------
  logic [3:0] meta;
  logic [3:0] sync;
  logic [1:0] prevBus;
  logic [3:0] next_meta;
  logic [3:0] next_sync;
  logic [1:0] next_prevBus;

  // Order: scl, sda, shutdown, refselect; first stage feeds only second
  always_comb begin
    next_meta = {refSelectPin, shutdownPinN, sdaPin, sclPin};
    next_sync = meta;
    next_prevBus = sync[1:0];
  end

  // Idle bus and pulled-up select pin read high out of reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta <= 4'hf;
      sync <= 4'hf;
      prevBus <= 2'h3;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prevBus <= next_prevBus;
    end
  end

  // Bus conditions compare the second stage with the registered copy behind it
  assign shutdownN = sync[2];
  assign refSelect = sync[3];
  assign sdaLevel = sync[1];
  assign sclRise = sync[0] && !prevBus[0];
  assign sclFall = !sync[0] && prevBus[0];
  assign startSeen = sync[0] && prevBus[0] && prevBus[1] && !sync[1];
  assign stopSeen = sync[0] && prevBus[0] && !prevBus[1] && sync[1];

endmodule

// ===== dv/tuner_cfg_assertions.sv
/*
  Checker for the tuner register bank, bound to its top module.
  Assumes the single ref_clk domain and the synchronous active-low nrst.
*/
`timescale 1ns/1ps

module tuner_cfg_assertions
  import tuner_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic sclPin,
  input wire logic sdaOe,
  input wire logic shutdownPinN,
  input wire logic refSelectPin,
  input wire logic [7:0] diagnosticTrimConfig,
  input wire logic [7:0] refclkDividerPower,
  input wire logic [12:0] loopDivide,
  input wire logic extRefEnable,
  input wire logic crystalEnable,
  input wire logic busActive,
  input wire logic chipActive,
  input wire logic synthActive,
  input wire logic quadOutputEnable
);
  // --------
  // Properties
  // --------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Four low samples: the synchroniser and the bus engine have both seen the pin
  a_bus_shut_off: assert property (!shutdownPinN [*4] |-> !busActive && !sdaOe)
    else $error("bus alive in shutdown");
  a_power_chain: assert property (!busActive |-> !(chipActive || synthActive
    || quadOutputEnable || extRefEnable || crystalEnable))
    else $error("enable alive in shutdown");
  a_soft_down: assert property (busActive |-> chipActive == !refclkDividerPower[2])
    else $error("soft power-down wrong");
  a_standby_quad: assert property (synthActive == (chipActive && !refclkDividerPower[1])
    && quadOutputEnable == (synthActive && !refclkDividerPower[0]))
    else $error("standby or quadrature wrong");
  // Pin held two samples, so a two-flop path has settled either way
  a_ref_pick: assert property (busActive && $past(nrst, 2)
    && $past(refSelectPin, 2) == $past(refSelectPin, 3)
    |-> extRefEnable == $past(refSelectPin, 2) && crystalEnable != $past(refSelectPin, 2))
    else $error("reference source wrong");
  // SDA may only move while SCL is low, or the host sees a false START or STOP
  a_sda_quiet: assert property (busActive && $changed(sdaOe) |-> !sclPin && !$past(sclPin))
    else $error("SDA moved with SCL high");
  a_write_slot: assert property (busActive && $past(busActive)
    && $changed({diagnosticTrimConfig, refclkDividerPower, loopDivide})
    |-> !sclPin && !$past(sclPin, 2))
    else $error("register changed outside a write");
  // Reset must act even while nrst is low, so this one is never disabled
  a_off_defaults: assert property (disable iff (1'b0) !busActive [*3]
    |-> diagnosticTrimConfig == CFG_RESET[0] && refclkDividerPower == CFG_RESET[4]
    && loopDivide == {CFG_RESET[6], CFG_RESET[7][7:3]})
    else $error("registers not at defaults");

  c_ack: cover property ($rose(sdaOe));
  c_soft_down: cover property (busActive && !chipActive);
  c_shutdown: cover property ($fell(busActive));
endmodule

bind tuner_config_register_bank tuner_cfg_assertions u_tuner_cfg_assertions (
  .ref_clk, .nrst, .sclPin, .sdaOe, .shutdownPinN, .refSelectPin, .diagnosticTrimConfig,
  .refclkDividerPower, .loopDivide, .extRefEnable, .crystalEnable, .busActive,
  .chipActive, .synthActive, .quadOutputEnable
);

// ===== dv/host_model.sv
/*
  Host controller on the two-wire bus: drives SCL and pulls SDA low.
  Assumes the bench resolves SDA with a pull-up and feeds it back.
*/
`timescale 1ns/1ps

module host_model (
  output logic scl,
  output logic sdaLow,
  input wire logic sdaLine
);
  // Quarter of a 400 ns SCL period; eight ref_clk cycles per bit is the least the
  // two-flop sampling and edge detection in the device can follow
  time q = 100;

  // Bus idles high: SCL stands still outside frames
  initial begin
    scl = 1'h1;
    sdaLow = 1'h0;
  end

  // One clock: data moves mid-low, is read mid-high
  task automatic bit1(input logic b, output logic got);
    #q sdaLow = !b;
    #q scl = 1'h1;
    #q got = sdaLine;
    #q scl = 1'h0;
  endtask

  task automatic start();
    #q sdaLow = 1'h0;
    #q scl = 1'h1;
    #q sdaLow = 1'h1;
    #q scl = 1'h0;
  endtask

  task automatic stop();
    #q sdaLow = 1'h1;
    #q scl = 1'h1;
    #q sdaLow = 1'h0;
    #q;
  endtask

  // Byte MSB first, then the ninth clock carries the ack
  task automatic xfer(input logic [7:0] d, input logic ackIn, output logic [7:0] got,
    output logic ackOut);
    for (int i = 7; i >= 0; i--) bit1(d[i], got[i]);
    bit1(ackIn, ackOut);
  endtask
endmodule

// ===== dv/tuner_config_register_bank_test.sv
/*
  Self-checking bench of the tuner register bank with a host bus model.
  Assumes pulled-up SDA and select pin; the bench drives the pull-up level.
*/
`timescale 1ns/1ps

module tuner_config_register_bank_test
  import tuner_cfg_pkg::*;
;
  typedef struct {
    string name;
    logic [15:0] v;
  } note_type;
  logic ref_clk = 1'h0, nrst = 1'h0, shutdownPinN = 1'h1, refSelectPin = 1'h1;
  logic [11:0] stat = 12'h0;
  logic sclPin, sdaPin, sdaOut, sdaOe, hostLow, autoselectSuccess, autoselectIdle;
  logic extRefEnable, crystalEnable, busActive, chipActive, synthActive, quadOutputEnable;
  logic [1:0] pumpCurrentActual, selOscIndex;
  logic [2:0] selSubband, tuneSampleCode;
  logic [7:0] diagnosticTrimConfig, synthLoopConfig, oscBandSelect, signalPathControl;
  logic [7:0] refclkDividerPower, clockInScaleValue, q;
  logic [7:0] wdata [8];
  logic [12:0] loopDivide;
  logic pwrFlag = 1'h1;
  int num_errors = 0, cmp_count = 0;
  note_type notes [$];
  note_type seenQ [$];
  event resultEv;

  // --------
  // Wiring
  // --------
  // Status inputs move together; SDA is open drain with a pull-up
  assign {pumpCurrentActual, autoselectSuccess, autoselectIdle, selOscIndex, selSubband,
    tuneSampleCode} = stat;
  assign sdaPin = (sdaOe ? sdaOut : 1'h1) && !hostLow;

  tuner_config_register_bank u_tuner_config_register_bank (
    .ref_clk, .nrst, .sclPin, .sdaPin, .sdaOut, .sdaOe, .shutdownPinN, .refSelectPin,
    .pumpCurrentActual, .autoselectSuccess, .autoselectIdle, .selOscIndex, .selSubband,
    .tuneSampleCode, .diagnosticTrimConfig, .synthLoopConfig, .oscBandSelect,
    .signalPathControl, .refclkDividerPower, .clockInScaleValue, .loopDivide,
    .extRefEnable, .crystalEnable, .busActive, .chipActive, .synthActive, .quadOutputEnable
  );
  host_model u_host_model (.scl(sclPin), .sdaLow(hostLow), .sdaLine(sdaPin));

  // --------
  // Checking
  // --------
  initial forever #25 ref_clk = !ref_clk;

  // Oldest note against each observed result; a burst from one time step is drained at once
  initial begin
    note_type n;
    note_type s;
    forever begin
      @(resultEv);
      while (seenQ.size() > 0) begin
        n = notes.pop_front();
        s = seenQ.pop_front();
        cmp_count++;
        if (n.v !== s.v) begin
          $display("unexpected %s: expected %h, seen %h", n.name, n.v, s.v);
          num_errors++;
        end
      end
    end
  end

  // Takes no time, so the host keeps its fixed offset after the clock edge
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    notes.push_back('{name, exp});
    seenQ.push_back('{name, got});
    ->resultEv;
  endtask

  // One step lets the watcher drain the results of the last time step
  task automatic results();
    #1;
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic pins(input logic s, input logic r);
    @(posedge ref_clk);
    #1 shutdownPinN = s;
    refSelectPin = r;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic send(input logic [7:0] b, input logic ackLvl);
    logic a;
    u_host_model.xfer(b, 1'h1, q, a);
    check("ack", {15'h0, ackLvl}, {15'h0, a});
  endtask

  // Burst from addr; the pointer steps once per data byte
  task automatic wr(input logic [7:0] addr, input int n, input logic ackLvl);
    u_host_model.start();
    send({DEVICE_ADDR, 1'h0}, ackLvl);
    send(addr, ackLvl);
    for (int i = 0; i < n; i++) send(wdata[(int'(addr) + i) % 8], ackLvl);
    u_host_model.stop();
  endtask

  task automatic rd(input int n);
    logic a;
    logic [7:0] st [2];
    st[0] = {3'h0, pumpCurrentActual, pwrFlag, autoselectSuccess, autoselectIdle};
    st[1] = {selOscIndex, selSubband, tuneSampleCode};
    u_host_model.start();
    send({DEVICE_ADDR, 1'h1}, 1'h0);
    for (int i = 0; i < n; i++) begin
      u_host_model.xfer(8'hff, i == n - 1, q, a);
      check("status", {8'h0, st[i % 2]}, {8'h0, q});
    end
    u_host_model.stop();
    pwrFlag = 1'h0;
  endtask

  task automatic check_regs();
    logic [7:0] got [6];
    got = '{diagnosticTrimConfig, synthLoopConfig, oscBandSelect, signalPathControl,
      refclkDividerPower, clockInScaleValue};
    for (int i = 0; i < 6; i++) check("cfg", {8'h0, wdata[i]}, {8'h0, got[i]});
    check("loopDivide", {3'h0, wdata[6], wdata[7][7:3]}, {3'h0, loopDivide});
  endtask

  // Bus traffic and the power-up wait need about 0.3 ms
  initial begin
    #1ms;
    num_errors++;
    results();
  end

  // --------
  // Scenarios
  // --------
  initial begin
    void'($urandom(32'he2f740d3));
    foreach (wdata[i]) wdata[i] = CFG_RESET[i];
    repeat (5) @(posedge ref_clk);
    #1 nrst = 1'h1;
    check_regs();
    repeat (POWERUP_WAIT_CYCLES) @(posedge ref_clk);
    for (int r = 0; r < 2; r++) begin
      pins(1'h1, r[0]);
      check("ref", {14'h0, r[0], !r[0]}, {14'h0, extRefEnable, crystalEnable});
    end
    @(posedge ref_clk);
    #1 stat = 12'($urandom);
    rd(3);
    rd(2);
    foreach (wdata[i]) wdata[i] = 8'($urandom);
    wr(8'h00, 8, 1'h0);
    check_regs();
    wdata[0] = ~wdata[0];
    wr(8'h08, 1, 1'h0);
    wdata[0] = ~wdata[0];
    check_regs();
    u_host_model.start();
    send({DEVICE_ADDR ^ 7'h01, 1'h0}, 1'h1);
    u_host_model.stop();
    for (int m = 0; m < 4; m++) begin
      wdata[4] = {5'($urandom), 3'(m == 3 ? 4 : m)};
      wr(8'h04, 1, 1'h0);
      check("power", {13'h0, !wdata[4][2], !wdata[4][2:1], !wdata[4][2:0]},
        {13'h0, chipActive, synthActive, quadOutputEnable});
    end
    wdata[1] = 8'($urandom);
    wr(8'h01, 1, 1'h0);
    check_regs();
    pins(1'h0, 1'h1);
    check("off", 16'h0,
      {11'h0, busActive, chipActive, synthActive, extRefEnable, crystalEnable});
    wr(8'h00, 1, 1'h1);
    pins(1'h1, 1'h1);
    foreach (wdata[i]) wdata[i] = CFG_RESET[i];
    pwrFlag = 1'h1;
    check_regs();
    rd(2);
    results();
  end
endmodule
